// File: npic_top.sv
// Nested priority interrupt controller with Wishbone register access.
`timescale 1ns/1ps
`include "npic_map.svh"
module npic_top #(
  parameter int NVEC = `NPIC_NUM_VEC,
  parameter int NEXT = `NPIC_NUM_EXT,
  parameter int PINS = 4
) (
  input wire logic clk_i,  // CPU clock
  input wire logic rst_i,  // Synchronous reset, active high
  input npic_pkg::npic_wb_req_t wb_i,  // Wishbone request
  output npic_pkg::npic_wb_rsp_t wb_o,  // Wishbone answer
  input npic_pkg::npic_core_in_t core_i,  // Core status
  output npic_pkg::npic_core_out_t core_o,  // Core control
  input wire logic [NEXT*PINS-1:0] pin_i,  // External pins
  input wire logic [NEXT*PINS-1:0] pin_sel_i,  // Pin selected for line
  input wire logic [NVEC-1:0] periph_flag_i,  // Peripheral flags
  input wire logic [NVEC-1:0] periph_en_i,  // Peripheral enables
  input wire logic [NVEC-1:0] periph_clr_i,  // Clear sequence pulses
  input wire logic [NVEC-1:0] halt_cap_i,  // Vector may exit Halt
  input wire logic top_line_i  // Top-level line request
);
  import npic_pkg::*;

  // The register map serves exactly fourteen vectors and one to four sense pairs.
  if (NVEC != 14 || NEXT < 1 || NEXT > 4 || PINS < 1) begin : g_chk
    $error("npic_top: unsupported parameter values");
  end

  localparam int VW = $clog2(NVEC + 1);

  typedef struct packed {
    npic_state_t st;
    logic [2*NVEC-1:0] prio;
    logic [2*NEXT-1:0] sense;
    logic [NVEC-1:0] ena;
    logic [NVEC-1:0] pend;
    logic [NEXT-1:0] line_q;
    logic [1:0] level;
    logic rst_pend;
    logic trap_pend;
    logic top_pend;
    logic top_q;
    logic [VW-1:0] sel;
    logic [1:0] sel_kind;
    logic ack;
    logic load;
    logic [7:0] rdat;
    logic [15:0] vector;
  } npic_state_s_t;

  npic_state_s_t s_q;
  npic_state_s_t s_d;

  logic [NEXT-1:0] line;
  logic [NVEC-1:0] raw;
  logic [NVEC-1:0] cand;
  logic [2*NVEC+1:0] prio_ext;

  // Pins of one group feed one line through an OR.
  genvar g;
  generate
    for (g = 0; g < NEXT; g++) begin : g_line
      assign line[g] = |(pin_i[g*PINS +: PINS] & pin_sel_i[g*PINS +: PINS]);
    end
  endgenerate

  // Peripheral request is flag and enable.
  always_comb begin
    raw = periph_flag_i & periph_en_i;
  end

  assign prio_ext = {2'b00, s_q.prio};

  // Ranks level as 0..3 with 3 highest.
  function automatic logic [1:0] rank(input logic [1:0] lv);
    unique case (lv)
      `NPIC_LVL_MAIN: rank = 2'd0;
      `NPIC_LVL_ONE: rank = 2'd1;
      `NPIC_LVL_TWO: rank = 2'd2;
      default: rank = 2'd3;
    endcase
  endfunction

  // Merges a write, keeping old pairs that receive the level-0 code.
  function automatic logic [7:0] prio_merge(input logic [7:0] old,
                                            input logic [7:0] wr);
    logic [7:0] r;
    r = wr;
    for (int k = 0; k < 4; k++) begin
      if (wr[2*k +: 2] == `NPIC_LVL_MAIN) begin
        r[2*k +: 2] = old[2*k +: 2];
      end
    end
    prio_merge = r;
  endfunction

  logic found;
  logic [VW-1:0] win;
  logic [1:0] win_rank;
  logic halt_mode;

  // Vector 0 has highest hardware priority; the scan runs downward and
  // greater-or-equal lets the lower index win a tie.
  always_comb begin
    found = 1'b0;
    win = '0;
    win_rank = 2'd0;
    halt_mode = core_i.halted;
    for (int v = NVEC - 1; v >= 0; v--) begin
      cand[v] = s_q.pend[v] & s_q.ena[v]
              & (rank(prio_ext[2*v +: 2]) > rank(s_q.level))
              & (~halt_mode | halt_cap_i[v]);
    end
    for (int v = NVEC - 1; v >= 0; v--) begin
      if (cand[v] && (!found || rank(prio_ext[2*v +: 2]) >= win_rank)) begin
        found = 1'b1;
        win = VW'(v);
        win_rank = rank(prio_ext[2*v +: 2]);
      end
    end
  end

  logic wr_acc;
  logic rd_acc;
  logic [7:0] prio3_new;

  assign prio3_new = prio_merge({4'hf, s_q.prio[27:24]},
                                {4'hf, wb_i.dat[3:0]});

  always_comb begin
    s_d = s_q;
    s_d.load = (s_q.st == NPIC_LOAD);
    // A write lands at the edge at which the master sees ack high.
    wr_acc = wb_i.cyc & wb_i.stb & wb_i.we & s_q.ack;
    rd_acc = wb_i.cyc & wb_i.stb & ~wb_i.we & ~s_q.ack;
    s_d.ack = wb_i.cyc & wb_i.stb & ~s_q.ack;
    s_d.line_q = line;
    s_d.top_q = top_line_i;
    if (core_i.trap) begin
      s_d.trap_pend = 1'b1;
    end
    if (top_line_i & ~s_q.top_q) begin
      s_d.top_pend = 1'b1;
    end
    // Latch peripheral levels here, external events further down; requests persist.
    for (int v = 0; v < NVEC; v++) begin
      if (raw[v]) begin
        s_d.pend[v] = 1'b1;
      end
      if (periph_clr_i[v] && !raw[v]) begin
        s_d.pend[v] = 1'b0;
      end
    end
    if (core_i.flags_we) begin
      s_d.level = core_i.flags_level;
    end
    if (core_i.ret) begin
      s_d.level = core_i.ret_level;
    end
    unique case (s_q.st)
      NPIC_IDLE: begin
        // Reset and trap outrank every maskable source; the top line does so only while the core is not halted.
        if (s_q.rst_pend) begin
          s_d.sel_kind = 2'd0;
          s_d.st = NPIC_WAIT_INSN;
        end else if (s_q.trap_pend) begin
          s_d.sel_kind = 2'd1;
          s_d.st = NPIC_WAIT_INSN;
        end else if (s_q.top_pend && !halt_mode) begin
          s_d.sel_kind = 2'd2;
          s_d.st = NPIC_WAIT_INSN;
        end else if (found) begin
          s_d.sel_kind = 2'd3;
          s_d.sel = win;
          s_d.st = NPIC_WAIT_INSN;
        end
      end
      NPIC_WAIT_INSN: begin
        if (core_i.insn_done || core_i.halted || core_i.waiting
            || s_q.sel_kind == 2'd0) begin
          s_d.st = (s_q.sel_kind == 2'd0) ? NPIC_LOAD : NPIC_STACK;
        end
      end
      NPIC_STACK: begin
        if (core_i.stack_done) begin
          s_d.st = NPIC_LOAD;
        end
      end
      NPIC_LOAD: begin
        s_d.st = NPIC_IDLE;
        unique case (s_q.sel_kind)
          2'd0: begin
            s_d.rst_pend = 1'b0;
            s_d.vector = `NPIC_VEC_RESET;
            s_d.level = `NPIC_LVL_DIS;
          end
          2'd1: begin
            s_d.trap_pend = core_i.trap;
            s_d.vector = `NPIC_VEC_TRAP;
            s_d.level = `NPIC_LVL_DIS;
          end
          2'd2: begin
            s_d.top_pend = top_line_i & ~s_q.top_q;
            s_d.vector = `NPIC_VEC_TOP_LINE;
            s_d.level = `NPIC_LVL_DIS;
          end
          2'd3: begin
            s_d.vector = `NPIC_VEC_BASE - {11'h0, s_q.sel, 1'b0};
            s_d.level = prio_ext[2*s_q.sel +: 2];
            if (!raw[s_q.sel]) begin
              s_d.pend[s_q.sel] = 1'b0;
            end
          end
        endcase
      end
    endcase
    // Edge events are latched after the entry clear, so that an edge in
    // the entry cycle is kept rather than lost.
    for (int e = 0; e < NEXT; e++) begin
      logic rise;
      logic fall;
      logic hit;
      hit = 1'b0;
      rise = line[e] & ~s_q.line_q[e];
      fall = ~line[e] & s_q.line_q[e];
      unique case (npic_sense_t'(s_q.sense[2*e +: 2]))
        NPIC_SENSE_FALL_LOW: hit = fall | ~line[e];
        NPIC_SENSE_RISE: hit = rise;
        NPIC_SENSE_FALL: hit = fall;
        NPIC_SENSE_BOTH: hit = rise | fall;
      endcase
      if (hit) begin
        s_d.pend[NVEC-NEXT+e] = 1'b1;
      end
    end
    if (wr_acc) begin
      unique case (wb_i.adr)
        `NPIC_ADR_PRIO0: s_d.prio[7:0] = prio_merge(s_q.prio[7:0], wb_i.dat);
        `NPIC_ADR_PRIO1: s_d.prio[15:8] = prio_merge(s_q.prio[15:8],
                                                     wb_i.dat);
        `NPIC_ADR_PRIO2: s_d.prio[23:16] = prio_merge(s_q.prio[23:16],
                                                      wb_i.dat);
        `NPIC_ADR_PRIO3: s_d.prio[27:24] = prio3_new[3:0];
        `NPIC_ADR_SENSE: s_d.sense = wb_i.dat[2*NEXT-1:0];
        `NPIC_ADR_ENA0: s_d.ena[7:0] = wb_i.dat;
        `NPIC_ADR_ENA1: s_d.ena[NVEC-1:8] = wb_i.dat[NVEC-9:0];
        default: ;
      endcase
    end
    s_d.rdat = 8'h00;
    if (rd_acc) begin
      unique case (wb_i.adr)
        `NPIC_ADR_PRIO0: s_d.rdat = s_q.prio[7:0];
        `NPIC_ADR_PRIO1: s_d.rdat = s_q.prio[15:8];
        `NPIC_ADR_PRIO2: s_d.rdat = s_q.prio[23:16];
        `NPIC_ADR_PRIO3: s_d.rdat = {4'hf, s_q.prio[27:24]};
        `NPIC_ADR_SENSE: s_d.rdat = 8'(s_q.sense);
        `NPIC_ADR_PEND: s_d.rdat = s_q.pend[7:0];
        `NPIC_ADR_PENDH: s_d.rdat = 8'(s_q.pend[NVEC-1:8]);
        `NPIC_ADR_FLAGS: begin
          s_d.rdat = 8'h00;
          s_d.rdat[`NPIC_FLAG_HI_BIT] = s_q.level[1];
          s_d.rdat[`NPIC_FLAG_LO_BIT] = s_q.level[0];
        end
        `NPIC_ADR_ENA0: s_d.rdat = s_q.ena[7:0];
        `NPIC_ADR_ENA1: s_d.rdat = 8'(s_q.ena[NVEC-1:8]);
        default: s_d.rdat = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.st <= NPIC_IDLE;
      s_q.prio <= '1;
      s_q.level <= `NPIC_LVL_DIS;
      s_q.rst_pend <= 1'b1;
      s_q.vector <= `NPIC_VEC_RESET;
      // Edge detectors start at the pin level, so no false edge follows.
      s_q.line_q <= line;
      s_q.top_q <= top_line_i;
    end else begin
      s_q <= s_d;
    end
  end

  // Four levels, sixteen vector slots from the top down.
  assign wb_o.ack = s_q.ack;
  assign wb_o.dat = s_q.rdat;
  assign core_o.take = (s_q.st != NPIC_IDLE);
  assign core_o.stack_req = (s_q.st == NPIC_STACK);
  assign core_o.skip_stack = (s_q.sel_kind == 2'd0);
  assign core_o.load_pc = s_q.load;
  assign core_o.vector = s_q.vector;
  assign core_o.wake = s_q.rst_pend | s_q.trap_pend | s_q.top_pend
                       | (found & core_i.halted)
                       | (|(s_q.pend & s_q.ena) & core_i.waiting);
  assign core_o.level = s_q.level;
endmodule

// File: npic_map.svh
// Offsets, field positions, reset values and codes of the interrupt controller.
`ifndef NPIC_MAP_SVH
`define NPIC_MAP_SVH
`define NPIC_NUM_VEC 14
`define NPIC_NUM_EXT 4
`define NPIC_ADR_PRIO0 4'h0
`define NPIC_ADR_PRIO1 4'h1
`define NPIC_ADR_PRIO2 4'h2
`define NPIC_ADR_PRIO3 4'h3
`define NPIC_ADR_SENSE 4'h4
`define NPIC_ADR_PEND 4'h5
`define NPIC_ADR_PENDH 4'h6
`define NPIC_ADR_FLAGS 4'h7
`define NPIC_ADR_ENA0 4'h8
`define NPIC_ADR_ENA1 4'h9
`define NPIC_PRIO_RST 8'hff
`define NPIC_LVL_MAIN 2'b10
`define NPIC_LVL_ONE 2'b01
`define NPIC_LVL_TWO 2'b00
`define NPIC_LVL_DIS 2'b11
`define NPIC_FLAG_HI_BIT 5
`define NPIC_FLAG_LO_BIT 3
`define NPIC_VEC_RESET 16'hfffe
`define NPIC_VEC_TRAP 16'hfffc
`define NPIC_VEC_BASE 16'hfffa
`define NPIC_VEC_TOP_LINE 16'hffe0
`endif

// File: npic_pkg.sv
// Types shared by the interrupt controller and its users.
package npic_pkg;
  typedef enum logic [1:0] {
    NPIC_SENSE_FALL_LOW,
    NPIC_SENSE_RISE,
    NPIC_SENSE_FALL,
    NPIC_SENSE_BOTH
  } npic_sense_t;
  typedef enum {
    NPIC_IDLE,
    NPIC_WAIT_INSN,
    NPIC_STACK,
    NPIC_LOAD
  } npic_state_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [7:0] dat;
  } npic_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [7:0] dat;
  } npic_wb_rsp_t;
  typedef struct packed {
    logic insn_done;
    logic trap;
    logic ret;
    logic [1:0] ret_level;
    logic stack_done;
    logic halted;
    logic waiting;
    logic flags_we;
    logic [1:0] flags_level;
  } npic_core_in_t;
  typedef struct packed {
    logic take;
    logic stack_req;
    logic skip_stack;
    logic load_pc;
    logic [15:0] vector;
    logic wake;
    logic [1:0] level;
  } npic_core_out_t;
endpackage

// File: npic_chk_sva.sv
// Port assertions for the interrupt controller.
`timescale 1ns/1ps
module npic_chk (
  input wire logic clk_i,  // Clock
  input wire logic rst_i,  // Reset
  input npic_pkg::npic_wb_req_t wb_i,  // Bus request
  input npic_pkg::npic_wb_rsp_t wb_o,  // Bus answer
  input npic_pkg::npic_core_in_t core_i,  // Core status
  input npic_pkg::npic_core_out_t core_o,  // Core control
  input wire logic top_line_i  // Top line
);
  import npic_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  AST_ACK: assert property (wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack)
    else $error("bus access not acknowledged");
  AST_RST_ENTRY: assert property (
    $fell(rst_i) |-> core_o.level == 2'b11 ##1
    core_o.take && core_o.skip_stack) else $error("reset entry wrong");
  AST_INSN_FIRST: assert property (
    $rose(core_o.stack_req) |->
    $past(core_i.insn_done || core_i.halted || core_i.waiting))
    else $error("stacking before instruction end");
  AST_STACK_IN_ENTRY: assert property (
    core_o.stack_req |-> core_o.take && !core_o.skip_stack)
    else $error("stacking outside entry");
  AST_LOAD: assert property (
    core_o.stack_req && core_i.stack_done |=> core_o.take ##1
    (!core_o.take && core_o.load_pc))
    else $error("vector load not after stacking");
  AST_NMI_LEVEL: assert property (
    $fell(core_o.take) && core_o.vector inside {16'hfffe, 16'hfffc} |->
    core_o.level == 2'b11) else $error("non-maskable level wrong");
  AST_TRAP: assert property (
    core_i.trap && !core_o.take |-> ##[1:8] core_o.take)
    else $error("trap not taken");
  AST_TOP: assert property (
    $rose(top_line_i) && !core_o.take && core_o.level != 2'b11 |->
    ##[1:8] core_o.take) else $error("top line not taken");
  AST_RET: assert property (
    core_i.ret && !core_o.take |=> core_o.level == $past(core_i.ret_level))
    else $error("return level wrong");
  AST_WAKE: assert property (
    $rose(core_o.take) && $past(core_i.halted) |-> $past(core_o.wake))
    else $error("entry from halt without wake");
  cover property (core_i.trap);
  cover property ($fell(core_o.take) && core_o.vector == 16'hffe0);
  cover property (core_i.ret && !core_o.take);
endmodule
bind npic_top npic_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
  .wb_o(wb_o), .core_i(core_i), .core_o(core_o), .top_line_i(top_line_i));

// File: npic_core_mdl.sv
// Behavioural processor core answering the controller's entry requests.
`timescale 1ns/1ps
module npic_core_mdl (
  input wire logic clk_i,  // Clock
  input wire logic rst_i,  // Reset
  input npic_pkg::npic_core_out_t core_o,  // Controller requests
  input npic_pkg::npic_core_in_t cmd_i,  // Events from the bench
  input wire logic [3:0] dly_i,  // Answer delay in cycles
  output npic_pkg::npic_core_in_t stat_o  // Core status
);
  import npic_pkg::*;
  logic [3:0] cnt_q;
  logic done_q;
  logic insn_q;
  logic stk_q;
  // The instruction end is reported once per entry, stacking once asked.
  always @(posedge clk_i) begin
    insn_q <= 1'b0;
    stk_q <= 1'b0;
    if (rst_i || !core_o.take) begin
      cnt_q <= 4'h0;
      done_q <= 1'b0;
    end else if (cnt_q < dly_i) begin
      cnt_q <= cnt_q + 4'h1;
    end else if (core_o.stack_req && !stk_q) begin
      stk_q <= 1'b1;
      cnt_q <= 4'h0;
    end else if (!done_q && !core_o.stack_req) begin
      insn_q <= 1'b1;
      done_q <= 1'b1;
      cnt_q <= 4'h0;
    end
  end
  // Return, trap and level writes come from the bench's program.
  always_comb begin
    stat_o = cmd_i;
    stat_o.insn_done = insn_q;
    stat_o.stack_done = stk_q;
  end
endmodule

// File: tb_nested_priority_interrupt_controller.sv
// Self-checking bench for the nested interrupt controller.
`timescale 1ns/1ps
module tb_nested_priority_interrupt_controller;
  import npic_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  npic_wb_req_t wb_i = '0;
  npic_wb_rsp_t wb_o;
  npic_core_in_t cmd = '0;
  npic_core_in_t core_i;
  npic_core_out_t core_o;
  logic [15:0] pin = 16'hffff;
  logic [13:0] flag = '0;
  logic [13:0] clr = '0;
  logic top = 1'b0;
  logic [3:0] dly = '0;
  logic [7:0] rd;
  logic sk;
  logic st;
  logic wk;
  int n_mismatch = 0;
  int checks = 0;
  always #2.5 clk_i = ~clk_i;
  npic_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
    .core_i(core_i), .core_o(core_o), .pin_i(pin), .pin_sel_i(16'hffff),
    .periph_flag_i(flag), .periph_en_i(14'h3fff), .periph_clr_i(clr),
    .halt_cap_i(14'h3fff), .top_line_i(top));
  npic_core_mdl i_core (.clk_i(clk_i), .rst_i(rst_i), .core_o(core_o),
    .cmd_i(cmd), .dly_i(dly), .stat_o(core_i));
  task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d);
    wb_i <= '{1'b1, 1'b1, we, a, d};
    do @(posedge clk_i); while (wb_o.ack !== 1'b1);
    rd = wb_o.dat;
    wb_i <= '0;
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    cmp(rd, e);
  endtask
  // Bit 2 trap, bit 1 return, bit 0 level write by the core.
  task automatic pulse(input logic [2:0] k, input logic [1:0] l);
    {cmd.trap, cmd.ret, cmd.flags_we} <= k;
    cmd.ret_level <= l;
    cmd.flags_level <= l;
    @(posedge clk_i);
    {cmd.trap, cmd.ret, cmd.flags_we} <= 3'b000;
  endtask
  task automatic span();
    int n = 0;
    wk = 1'b0;
    st = 1'b0;
    while (core_o.take !== 1'b1 && n++ < 40) begin
      wk |= core_o.wake;
      @(posedge clk_i);
    end
    sk = core_o.skip_stack;
    while (core_o.take === 1'b1 && n++ < 80) begin
      st |= core_o.stack_req;
      @(posedge clk_i);
    end
  endtask
  task automatic entry(input logic [15:0] v, input logic [1:0] l,
      input logic s);
    span();
    cmp({core_o.level, sk, st, core_o.vector}, {l, s, ~s, v});
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    entry(16'hfffe, 2'b11, 1'b1);
    rdc(4'h7, 8'h28);
    rdc(4'h3, 8'hff);
    rdc(4'hc, 8'h00);
    wb(1'b1, 4'h1, 8'hcf);
    wb(1'b1, 4'h1, 8'h64);
    rdc(4'h1, 8'h44);
    wb(1'b1, 4'h0, 8'h05);
    wb(1'b1, 4'h8, 8'hff);
    wb(1'b1, 4'h9, 8'h3f);
    flag <= 14'h0006;
    repeat (4) @(posedge clk_i);
    cmp(core_o.take, 1'b0);
    rdc(4'h5, 8'h06);
    pulse(3'b001, 2'b10);
    entry(16'hfff6, 2'b00, 1'b0);
    flag <= 14'h000f;
    repeat (4) @(posedge clk_i);
    cmp(core_o.take, 1'b0);
    flag <= 14'h000b;
    clr <= 14'h0004;
    @(posedge clk_i);
    clr <= '0;
    rdc(4'h5, 8'h0b);
    pulse(3'b010, 2'b10);
    entry(16'hfff4, 2'b00, 1'b0);
    flag <= 14'h0003;
    clr <= 14'h0008;
    @(posedge clk_i);
    clr <= '0;
    dly <= 4'h3;
    pulse(3'b010, 2'b10);
    entry(16'hfffa, 2'b01, 1'b0);
    rdc(4'h7, 8'h08);
    flag <= '0;
    clr <= 14'h0003;
    @(posedge clk_i);
    clr <= '0;
    pulse(3'b010, 2'b10);
    rdc(4'h7, 8'h20);
    pulse(3'b100, 2'b00);
    entry(16'hfffc, 2'b11, 1'b0);
    pulse(3'b010, 2'b10);
    wb(1'b1, 4'h4, 8'h01);
    pin <= 16'hfff0;
    cmd.halted <= 1'b1;
    @(posedge clk_i);
    pin <= 16'hffff;
    entry(16'hffe6, 2'b11, 1'b0);
    cmp(wk, 1'b1);
    cmd.halted <= 1'b0;
    rdc(4'h5, 8'h00);
    rdc(4'h6, 8'h00);
    pulse(3'b010, 2'b10);
    top <= 1'b1;
    entry(16'hffe0, 2'b11, 1'b0);
    give_verdict();
  end
endmodule
